// *** hw/fral_params.svh ***
// Function
// - Four range types chosen by range type.
// - Auto ranging uses 0 to 25% hysteresis.
// - Two range outputs show the active range.
// - Bidirectional auto applies hysteresis on direction change.
// - Unidirectional external: input level picks range.
// - Bidirectional external: direction plus input pick range.
// - Limit alarms clear after 2.5% hysteresis.
// - Alarm switched off is never asserted.
// - Multi-range alarms drive separate high, low outputs.
// - Preset output on above count; one-shot ends.
// - Level-hold preset stays on until totalizer reset.
// - External input resets totalizer at chosen level.
// - Long one-shot pulse keeps output on.
// - External input starts zero adjustment.
// - ROM or RAM diagnosis error raises failure contact.
// - Highest-ranked detected error is reported as message.
// - Unit change leaves current span unchanged.
// - Functions assigned to two contacts, one input.
// - One-shot width settable 0.3 to 500 ms.
`ifndef FRAL_PARAMS_SVH
`define FRAL_PARAMS_SVH

// Register byte offsets.
`define FRAL_CTRL_OFS 8'h00
`define FRAL_THR01_OFS 8'h04
`define FRAL_THR2_OFS 8'h08
`define FRAL_HILO_OFS 8'h0c
`define FRAL_HHLL_OFS 8'h10
`define FRAL_PRESET_OFS 8'h14
`define FRAL_PWIDTH_OFS 8'h18
`define FRAL_SPAN_OFS 8'h1c
`define FRAL_UNIT_OFS 8'h20
`define FRAL_STATUS_OFS 8'h24
`define FRAL_COUNT_OFS 8'h28

// Control field positions and reset value.
`define FRAL_CTRL_W 18
`define FRAL_CTRL_TCLR 17
`define FRAL_CTRL_RST 18'h0_0000

// Rates and limits are in 0.1% of full scale.
`define FRAL_ALM_HYS 25
`define FRAL_HYS_MAX 250

// Timing: clock period, width tick, one-shot width bounds.
`define FRAL_CLK_NS 8
`define FRAL_TICK_US 100
`define FRAL_PW_MIN_US 300
`define FRAL_PW_MAX_US 500000
`define FRAL_PW_MIN (`FRAL_PW_MIN_US / `FRAL_TICK_US)
`define FRAL_PW_MAX (`FRAL_PW_MAX_US / `FRAL_TICK_US)

// Diagnosis flag bits and message codes.
`define FRAL_ERR_ROM 0
`define FRAL_ERR_RAM 1
`define FRAL_ERR_PARAM 2
`define FRAL_ERR_EXC 3
`define FRAL_MSG_NONE 4'h0
`define FRAL_MSG_ROM 4'h1
`define FRAL_MSG_RAM 4'h2
`define FRAL_MSG_PARAM 4'h3
`define FRAL_MSG_EXC 4'h4
`define FRAL_MSG_HI 4'h5
`define FRAL_MSG_LO 4'h6
`define FRAL_MSG_HH 4'h7
`define FRAL_MSG_LL 4'h8

`endif

// *** hw/fral_pkg.sv ***
package fral_pkg;
  typedef enum logic [1:0] {
    RT_UNI_AUTO = 2'b00,
    RT_BI_AUTO = 2'b01,
    RT_UNI_EXT = 2'b10,
    RT_BI_EXT = 2'b11
  } fral_rtype_t;
  typedef enum logic [1:0] {
    EF_RANGE = 2'b00,
    EF_TOTAL = 2'b01,
    EF_ZERO = 2'b10,
    EF_NONE = 2'b11
  } fral_efunc_t;
  typedef enum logic [2:0] {
    DF_RNG1 = 3'b000,
    DF_RNG2 = 3'b001,
    DF_HIGH = 3'b010,
    DF_LOW = 3'b011,
    DF_HHLL = 3'b100,
    DF_PRESET = 3'b101,
    DF_FAIL = 3'b110,
    DF_OFF = 3'b111
  } fral_dfunc_t;
  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_HOLD = 2'b01,
    PS_PULSE = 2'b10
  } fral_pstate_t;
  typedef struct packed {
    logic tclr;
    fral_dfunc_t do2;
    fral_dfunc_t do1;
    logic multi;
    logic [3:0] alm_en;
    logic oneshot;
    logic di_high;
    fral_efunc_t efunc;
    fral_rtype_t rtype;
  } fral_ctrl_t;
endpackage

// *** hw/fral_hyst_cmp.sv ***
`timescale 1ns/10ps
`include "fral_params.svh"

module fral_hyst_cmp #(
  parameter int WID = 17,
  parameter int HYS = `FRAL_ALM_HYS
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Control.
  input wire logic i_upd,
  input wire logic i_en,
  input wire logic i_high,
  // Operands.
  input wire logic signed [WID-1:0] i_val,
  input wire logic signed [WID-1:0] i_lim,
  // Result.
  output logic o_alm
);
  localparam logic signed [WID:0] HV = (WID+1)'(HYS);

  // The band must be non-negative and the operands need a sign bit.
  if (WID < 2 || HYS < 0) begin : g_bad
    $error("fral_hyst_cmp: WID must be 2 or more and HYS not negative.");
  end

  logic signed [WID:0] v;
  logic signed [WID:0] l;
  logic next_alm;
  // One guard bit so limit plus band never wraps.
  assign v = (WID+1)'(i_val);
  assign l = (WID+1)'(i_lim);

  // Set past the limit, release only once back inside by the band.
  always_comb begin
    next_alm = o_alm;
    if (!i_en) begin
      next_alm = 1'b0;
    end else if (i_upd) begin
      if (!o_alm) begin
        next_alm = i_high ? (v > l) : (v < l);
      end else begin
        next_alm = i_high ? !(v < l - HV) : !(v > l + HV);
      end
    end
  end

  // Alarm flop.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_alm <= 1'b0;
    end else begin
      o_alm <= next_alm;
    end
  end

  a_alarm_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !i_en |=> !o_alm) else $error("Disabled alarm asserted.");
  a_alarm_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (o_alm && i_en && i_upd && i_high && (v >= l - HV)) |=> o_alm)
    else $error("High alarm released inside hysteresis band.");
endmodule // fral_hyst_cmp

// *** hw/fral_top.sv ***
`timescale 1ns/10ps
`include "fral_params.svh"

module fral_top #(
  parameter int W = 16,
  parameter int TICK_CYC = `FRAL_TICK_US * 1000 / `FRAL_CLK_NS
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Measurement and totalizer feed.
  input wire logic i_meas_valid,
  input wire logic signed [W-1:0] i_meas_rate,
  input wire logic i_count_pulse,
  // Self-diagnosis flags.
  input wire logic [3:0] i_diag_err,
  // Terminals.
  input wire logic i_external_input,
  output logic o_contact_output_one,
  output logic o_contact_output_two,
  // Side outputs.
  output logic [1:0] o_range,
  output logic o_zero_adj_start,
  output logic o_total_reset,
  output logic [15:0] o_span,
  output logic [3:0] o_msg_code
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [W-1:0] HYS_MAX = W'(`FRAL_HYS_MAX);
  localparam logic [12:0] PW_MIN = 13'(`FRAL_PW_MIN);
  localparam logic [12:0] PW_MAX = 13'(`FRAL_PW_MAX);

  // Packing assumes limits fit one half word.
  if (W < 8 || W > 16 || TICK_CYC < 1) begin : g_bad
    $error("fral_top: W must be 8..16 and TICK_CYC positive.");
  end

  // Register state.
  fral_pkg::fral_ctrl_t ctrl, next_ctrl;
  logic [W-1:0] cfg [8];
  logic [W-1:0] next_cfg [8];
  logic [31:0] preset, next_preset;
  logic [12:0] pwidth, next_pwidth;
  logic [15:0] next_span;
  logic [3:0] unit, next_unit;
  logic tclr, next_tclr;
  logic [31:0] next_rdata;
  logic next_pready, next_slverr, hit, acc, wr_acc;
  logic [2:0] pair;

  // Block state.
  logic [1:0] next_range;
  logic fwd, next_fwd;
  logic [3:0] alm;
  logic di_s1, di_s2, di_q;
  logic di_act, zstart, total_rst;
  logic [31:0] count, next_count;
  logic over, over_q, rise;
  fral_pkg::fral_pstate_t pstate, next_pstate;
  logic [12:0] pw_cnt, next_pw_cnt;
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic tick, preset_on, fail;
  logic [7:0] src;
  logic [3:0] next_msg;

  assign acc = i_psel & i_penable;
  assign wr_acc = acc & o_pready & i_pwrite;
  assign pair = i_paddr[4:2] - 3'h1;

  // Decode; one wait state so read data can come from a flop.
  always_comb begin
    hit = 1'b1;
    next_rdata = 32'h0000_0000;
    case (i_paddr)
      `FRAL_CTRL_OFS: next_rdata = 32'(ctrl);
      `FRAL_THR01_OFS, `FRAL_THR2_OFS, `FRAL_HILO_OFS, `FRAL_HHLL_OFS:
        next_rdata = (32'(cfg[{pair[1:0], 1'b1}]) << 16) |
                     32'(cfg[{pair[1:0], 1'b0}]);
      `FRAL_PRESET_OFS: next_rdata = preset;
      `FRAL_PWIDTH_OFS: next_rdata = 32'(pwidth);
      `FRAL_SPAN_OFS: next_rdata = 32'(o_span);
      `FRAL_UNIT_OFS: next_rdata = 32'(unit);
      `FRAL_STATUS_OFS: next_rdata = {16'h0000, o_msg_code, fail,
        preset_on, ctrl.multi & (alm[1] | alm[3]),
        ctrl.multi & (alm[0] | alm[2]), alm, 1'b0, fwd, o_range};
      `FRAL_COUNT_OFS: next_rdata = count;
      default: hit = 1'b0;
    endcase
    next_pready = acc & ~o_pready;
    next_slverr = acc & ~o_pready & ~hit;
  end

  // Register writes take effect on the completing edge only.
  always_comb begin
    next_ctrl = ctrl;
    next_cfg = cfg;
    next_preset = preset;
    next_pwidth = pwidth;
    next_span = o_span;
    next_unit = unit;
    next_tclr = 1'b0;
    if (wr_acc) begin
      case (i_paddr)
        `FRAL_CTRL_OFS: begin
          next_ctrl = fral_pkg::fral_ctrl_t'(i_pwdata[`FRAL_CTRL_W-1:0]);
          next_ctrl.tclr = 1'b0;
          next_tclr = i_pwdata[`FRAL_CTRL_TCLR];
        end
        `FRAL_THR01_OFS, `FRAL_THR2_OFS, `FRAL_HILO_OFS, `FRAL_HHLL_OFS:
        begin
          next_cfg[{pair[1:0], 1'b0}] = i_pwdata[W-1:0];
          next_cfg[{pair[1:0], 1'b1}] = i_pwdata[16+W-1:16];
        end
        `FRAL_PRESET_OFS: next_preset = i_pwdata;
        `FRAL_PWIDTH_OFS: begin
          if (i_pwdata < 32'(PW_MIN)) begin
            next_pwidth = PW_MIN;
          end else if (i_pwdata > 32'(PW_MAX)) begin
            next_pwidth = PW_MAX;
          end else begin
            next_pwidth = i_pwdata[12:0];
          end
        end
        `FRAL_SPAN_OFS: next_span = i_pwdata[15:0];
        // The unit only scales the display; span stays as it is.
        `FRAL_UNIT_OFS: next_unit = i_pwdata[3:0];
        default: ;
      endcase
    end
    if (next_cfg[3] > HYS_MAX) begin
      next_cfg[3] = HYS_MAX;
    end
  end

  // Register and APB flops.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl <= fral_pkg::fral_ctrl_t'(`FRAL_CTRL_RST);
      for (int k = 0; k < 8; k++) begin
        cfg[k] <= '0;
      end
      preset <= 32'h0000_0000;
      pwidth <= PW_MIN;
      o_span <= 16'h0000;
      unit <= 4'h0;
      tclr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      preset <= next_preset;
      pwidth <= next_pwidth;
      o_span <= next_span;
      unit <= next_unit;
      tclr <= next_tclr;
      o_prdata <= next_pready ? next_rdata : 32'h0000_0000;
      o_pready <= next_pready;
      o_pslverr <= next_slverr;
    end
  end

  // External input synchroniser; active level is software chosen.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      di_s1 <= 1'b0;
      di_s2 <= 1'b0;
      di_q <= 1'b0;
    end else begin
      di_s1 <= i_external_input;
      di_s2 <= di_s1;
      di_q <= di_s2;
    end
  end
  assign di_act = (di_s2 == ctrl.di_high);
  // Edge taken on the synced pin, so a polarity write starts nothing.
  assign zstart = (ctrl.efunc == fral_pkg::EF_ZERO) & di_act &
    (di_s2 != di_q);
  assign total_rst = tclr |
    ((ctrl.efunc == fral_pkg::EF_TOTAL) & di_act);

  // Range choice, re-evaluated on each measurement update.
  logic signed [W:0] rate_x, hys_s;
  logic [W:0] mag;
  logic [W+1:0] mag_dn;
  logic [W-1:0] th_up, th_dn;
  logic sub;
  always_comb begin
    rate_x = (W+1)'(i_meas_rate);
    hys_s = signed'({1'b0, cfg[3]});
    mag = unsigned'(rate_x[W] ? -rate_x : rate_x);
    mag_dn = {1'b0, mag} + {2'b00, cfg[3]};
    th_up = cfg[{1'b0, o_range}];
    th_dn = cfg[{1'b0, o_range - 2'h1}];
    next_range = o_range;
    next_fwd = fwd;
    sub = o_range[0];
    if (i_meas_valid) begin
      case (ctrl.rtype)
        fral_pkg::RT_UNI_AUTO: begin
          if (o_range != 2'h3 && mag > {1'b0, th_up}) begin
            next_range = o_range + 2'h1;
          end else if (o_range != 2'h0 && mag_dn < {2'b00, th_dn}) begin
            next_range = o_range - 2'h1;
          end
        end
        fral_pkg::RT_BI_AUTO: begin
          if (fwd && rate_x < -hys_s) begin
            next_fwd = 1'b0;
          end else if (!fwd && rate_x > hys_s) begin
            next_fwd = 1'b1;
          end
          if (!sub && mag > {1'b0, cfg[0]}) begin
            sub = 1'b1;
          end else if (sub && mag_dn < {2'b00, cfg[0]}) begin
            sub = 1'b0;
          end
          next_range = {~next_fwd, sub};
        end
        fral_pkg::RT_UNI_EXT: begin
          next_range = {1'b0, di_act};
        end
        default: begin
          next_fwd = ~rate_x[W];
          next_range = {rate_x[W], di_act};
        end
      endcase
    end
  end

  // Range flops drive the range outputs directly.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_range <= 2'h0;
      fwd <= 1'b1;
    end else begin
      o_range <= next_range;
      fwd <= next_fwd;
    end
  end

  // Limit alarms: hi, lo, high-high, low-low.
  for (genvar k = 0; k < 4; k++) begin : g_alm
    fral_hyst_cmp #(.WID(W + 1), .HYS(`FRAL_ALM_HYS)) u_cmp (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_upd(i_meas_valid),
      .i_en(ctrl.alm_en[k]),
      .i_high(k % 2 == 0),
      .i_val(rate_x),
      .i_lim(signed'({cfg[4+k][W-1], cfg[4+k]})),
      .o_alm(alm[k])
    );
  end

  // Width tick divider; a free-running tick costs one tick of jitter.
  assign tick = (tick_cnt == TW'(TICK_CYC - 1));
  assign next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
  assign over = (count > preset);
  assign rise = over & ~over_q;
  assign preset_on = (pstate != fral_pkg::PS_OFF);

  // Totalizer and preset state machine.
  always_comb begin
    next_count = count;
    if (total_rst) begin
      next_count = 32'h0000_0000;
    end else if (i_count_pulse) begin
      next_count = count + 32'h0000_0001;
    end
    next_pstate = pstate;
    next_pw_cnt = pw_cnt;
    case (pstate)
      fral_pkg::PS_OFF: begin
        if (rise) begin
          next_pstate = ctrl.oneshot ? fral_pkg::PS_PULSE
                                     : fral_pkg::PS_HOLD;
          next_pw_cnt = pwidth;
        end
      end
      fral_pkg::PS_HOLD: begin
        if (total_rst) begin
          next_pstate = fral_pkg::PS_OFF;
        end
      end
      fral_pkg::PS_PULSE: begin
        // A new crossing restarts the width, so close events merge.
        if (rise) begin
          next_pw_cnt = pwidth;
        end else if (tick) begin
          if (pw_cnt <= 13'h0001) begin
            next_pstate = fral_pkg::PS_OFF;
          end else begin
            next_pw_cnt = pw_cnt - 13'h0001;
          end
        end
      end
      default: next_pstate = fral_pkg::PS_OFF;
    endcase
  end

  // Totalizer, preset and divider flops.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= 32'h0000_0000;
      over_q <= 1'b0;
      pstate <= fral_pkg::PS_OFF;
      pw_cnt <= 13'h0000;
      tick_cnt <= '0;
    end else begin
      count <= next_count;
      over_q <= over;
      pstate <= next_pstate;
      pw_cnt <= next_pw_cnt;
      tick_cnt <= next_tick_cnt;
    end
  end

  // Contact sources indexed by the function code of each terminal.
  assign fail = i_diag_err[`FRAL_ERR_ROM] | i_diag_err[`FRAL_ERR_RAM];
  assign src = {1'b0, fail, preset_on, alm[2] | alm[3],
    ctrl.multi ? (alm[1] | alm[3]) : alm[1],
    ctrl.multi ? (alm[0] | alm[2]) : alm[0], o_range};

  // Hardware faults outrank setting errors, which outrank alarms.
  always_comb begin
    next_msg = `FRAL_MSG_NONE;
    if (i_diag_err[`FRAL_ERR_ROM]) next_msg = `FRAL_MSG_ROM;
    else if (i_diag_err[`FRAL_ERR_RAM]) next_msg = `FRAL_MSG_RAM;
    else if (i_diag_err[`FRAL_ERR_PARAM]) next_msg = `FRAL_MSG_PARAM;
    else if (i_diag_err[`FRAL_ERR_EXC]) next_msg = `FRAL_MSG_EXC;
    else if (alm[0]) next_msg = `FRAL_MSG_HI;
    else if (alm[1]) next_msg = `FRAL_MSG_LO;
    else if (alm[2]) next_msg = `FRAL_MSG_HH;
    else if (alm[3]) next_msg = `FRAL_MSG_LL;
  end

  // Terminal and event output flops.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_contact_output_one <= 1'b0;
      o_contact_output_two <= 1'b0;
      o_zero_adj_start <= 1'b0;
      o_total_reset <= 1'b0;
      o_msg_code <= `FRAL_MSG_NONE;
    end else begin
      o_contact_output_one <= src[ctrl.do1];
      o_contact_output_two <= src[ctrl.do2];
      o_zero_adj_start <= zstart;
      o_total_reset <= total_rst;
      o_msg_code <= next_msg;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  a_uni_ext_rng: assert property (
    (i_meas_valid && ctrl.rtype == fral_pkg::RT_UNI_EXT)
    |=> o_range == {1'b0, $past(di_act)}) else $error("Bad ext range.");
  a_bi_ext_rng: assert property (
    (i_meas_valid && ctrl.rtype == fral_pkg::RT_BI_EXT)
    |=> o_range == {$past(rate_x[W]), $past(di_act)})
    else $error("Bad bidirectional ext range.");
  a_hys_limit: assert property (cfg[3] <= HYS_MAX)
    else $error("Range hysteresis above limit.");
  a_pw_limits: assert property (
    pwidth >= PW_MIN && pwidth <= PW_MAX) else $error("Width out of range.");
  a_fail_out: assert property (
    (fail && ctrl.do1 == fral_pkg::DF_FAIL && $stable(ctrl))
    |=> o_contact_output_one) else $error("Failure contact not on.");
  a_preset_on: assert property (
    (rise && !total_rst) |=> preset_on ##1 (preset_on || $past(total_rst)))
    else $error("Preset output did not turn on.");
  a_hold_keep: assert property (
    (pstate == fral_pkg::PS_HOLD && !total_rst) |=> pstate == fral_pkg::PS_HOLD)
    else $error("Held preset dropped without reset.");
  a_pulse_end: assert property (
    (pstate == fral_pkg::PS_PULSE && tick && pw_cnt <= 13'h0001 && !rise)
    |=> pstate == fral_pkg::PS_OFF) else $error("One-shot overran.");
  a_zero_start: assert property (zstart |=> o_zero_adj_start)
    else $error("Zero adjust start missed.");
  a_total_clr: assert property (total_rst |=> count == 32'h0000_0000)
    else $error("Totalizer not cleared.");

  c_pulse_done: cover property (pstate == fral_pkg::PS_PULSE
    ##1 pstate == fral_pkg::PS_OFF);
  c_range_up: cover property (o_range == 2'h0 ##1 o_range == 2'h1);
  c_dir_flip: cover property (fwd ##1 !fwd);
  c_fail_seen: cover property (fail && o_contact_output_one);
endmodule // fral_top

// *** tb/fral_pcs_model.sv ***
`timescale 1ns/10ps

module fral_pcs_model (
  // Clock.
  input wire logic i_core_clk,
  // Contacts seen by the control system.
  input wire logic i_contact_output_one,
  input wire logic i_contact_output_two,
  // Level driven onto the external input pin.
  output logic o_external_input
);
  logic lvl;
  logic prev_two;
  int rises;

  // The system holds its chosen level; it never releases the pin.
  initial begin
    lvl = 1'b0;
    o_external_input = 1'b0;
    prev_two = 1'b0;
    rises = 0;
  end

  task automatic set_level(input logic v);
    lvl = v;
  endtask

  // Level changes land just after a rising edge, like a real driver.
  always @(posedge i_core_clk) begin
    o_external_input <= lvl;
    prev_two <= i_contact_output_two;
    if (i_contact_output_two && !prev_two) begin
      rises++;
    end
  end
endmodule // fral_pcs_model

// *** tb/fral_top_tb.sv ***
`timescale 1ns/10ps
`include "fral_params.svh"

module fral_top_tb;
  localparam int TICK = 4;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, q;
  logic vld = 0, cpulse = 0, err, pin;
  logic signed [15:0] rate = 16'sh0000;
  logic [3:0] diag = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, c1, c2, zst, trst;
  logic [1:0] rng;
  logic [15:0] span;
  logic [3:0] msg;
  fral_pkg::fral_ctrl_t c;
  int errors = 0, total_checks = 0;
  int zpulses = 0;

  fral_top #(.TICK_CYC(TICK)) i_fral_top (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_meas_valid(vld), .i_meas_rate(rate),
    .i_count_pulse(cpulse), .i_diag_err(diag),
    .i_external_input(pin), .o_contact_output_one(c1),
    .o_contact_output_two(c2), .o_range(rng),
    .o_zero_adj_start(zst), .o_total_reset(trst), .o_span(span),
    .o_msg_code(msg));
  fral_pcs_model i_fral_pcs_model (.i_core_clk(clk),
    .i_contact_output_one(c1), .i_contact_output_two(c2),
    .o_external_input(pin));

  // A 125 MHz clock.
  always #4 clk = ~clk;

  // Counts zero-start pulses, so a stray one is caught as well.
  always @(posedge clk) begin
    if (zst === 1'b1) zpulses++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // An idle edge, so the next call never drives psel twice at once.
    @(posedge clk);
  endtask

  task automatic wctrl();
    apb(1'b1, `FRAL_CTRL_OFS, 32'(c));
  endtask

  task automatic meas(input logic signed [15:0] r);
    vld <= 1'b1;
    rate <= r;
    @(posedge clk);
    vld <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic counts(input int n);
    repeat (n) begin
      cpulse <= 1'b1;
      @(posedge clk);
      cpulse <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic pin_to(input logic v);
    i_fral_pcs_model.set_level(v);
    repeat (5) @(posedge clk);
  endtask

  // Reset values, refused addresses and span held over a unit change.
  task automatic t_regs();
    apb(1'b0, `FRAL_CTRL_OFS, 32'h0);
    chk(q, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0000_0000);
    chk(err, 32'h0000_0001);
    apb(1'b1, `FRAL_SPAN_OFS, 32'h0000_1234);
    apb(1'b1, `FRAL_UNIT_OFS, 32'h0000_0005);
    chk(span, 32'h0000_1234);
    $display("t_regs done");
  endtask

  // Auto ranging steps only past the hysteresis band.
  task automatic t_auto();
    c = '0;
    wctrl();
    apb(1'b1, `FRAL_THR01_OFS, {16'd200, 16'd100});
    apb(1'b1, `FRAL_THR2_OFS, {16'd300, 16'd300});
    apb(1'b0, `FRAL_THR2_OFS, 32'h0);
    chk(q[31:16], 32'd250);
    apb(1'b1, `FRAL_THR2_OFS, {16'd20, 16'd300});
    meas(16'sd150);
    chk(rng, 32'd1);
    meas(16'sd90);
    chk(rng, 32'd1);
    meas(16'sd70);
    chk(rng, 32'd0);
    c.rtype = fral_pkg::RT_BI_AUTO;
    wctrl();
    meas(-16'sd150);
    chk(rng, 32'd3);
    meas(16'sd10);
    chk(rng, 32'd2);
    meas(16'sd30);
    chk(rng, 32'd0);
    $display("t_auto done");
  endtask

  // External selection, one and two directions.
  task automatic t_ext();
    c = '0;
    c.rtype = fral_pkg::RT_UNI_EXT;
    c.di_high = 1'b1;
    wctrl();
    pin_to(1'b1);
    meas(16'sd100);
    chk({rng, c1}, 32'h3);
    pin_to(1'b0);
    meas(16'sd100);
    chk(rng, 32'd0);
    c.rtype = fral_pkg::RT_BI_EXT;
    wctrl();
    pin_to(1'b1);
    meas(-16'sd100);
    chk(rng, 32'd3);
    $display("t_ext done");
  endtask

  // High and low alarms with 2.5 percent release band, then off.
  task automatic t_alarm();
    c = '0;
    c.alm_en = 4'b0011;
    c.do1 = fral_pkg::DF_HIGH;
    c.do2 = fral_pkg::DF_LOW;
    wctrl();
    apb(1'b1, `FRAL_HILO_OFS, {-16'sd500, 16'sd500});
    meas(16'sd510);
    chk({c1, c2}, 32'h2);
    meas(16'sd480);
    chk(c1, 32'h1);
    meas(16'sd470);
    chk(c1, 32'h0);
    meas(-16'sd510);
    chk({c1, c2}, 32'h1);
    c.multi = 1'b1;
    c.alm_en = 4'b0100;
    c.do2 = fral_pkg::DF_HHLL;
    wctrl();
    apb(1'b1, `FRAL_HHLL_OFS, {-16'sd800, 16'sd800});
    meas(16'sd900);
    chk({c1, c2}, 32'h3);
    c.alm_en = 4'b0000;
    wctrl();
    meas(16'sd600);
    chk(c1, 32'h0);
    $display("t_alarm done");
  endtask

  // Level hold until cleared, then a one-shot of PWIDTH ticks.
  task automatic t_preset();
    c = '0;
    c.do2 = fral_pkg::DF_PRESET;
    c.tclr = 1'b1;
    wctrl();
    apb(1'b1, `FRAL_PRESET_OFS, 32'd3);
    counts(3);
    chk(c2, 32'h0);
    counts(1);
    apb(1'b0, `FRAL_COUNT_OFS, 32'h0);
    chk(q, 32'd4);
    chk(c2, 32'h1);
    repeat (40) @(posedge clk);
    chk(c2, 32'h1);
    wctrl();
    repeat (3) @(posedge clk);
    chk(c2, 32'h0);
    c.oneshot = 1'b1;
    wctrl();
    apb(1'b1, `FRAL_PWIDTH_OFS, 32'd1);
    apb(1'b0, `FRAL_PWIDTH_OFS, 32'h0);
    chk(q, 32'd3);
    apb(1'b1, `FRAL_PWIDTH_OFS, 32'd10);
    i_fral_pcs_model.rises = 0;
    counts(4);
    chk(c2, 32'h1);
    // A second crossing inside the width must stretch the pulse.
    wctrl();
    counts(4);
    repeat (7 * TICK) @(posedge clk);
    chk(c2, 32'h1);
    repeat (5 * TICK) @(posedge clk);
    chk({c2, 8'(i_fral_pcs_model.rises)}, 32'h1);
    $display("t_preset done");
  endtask

  // Zero start pulse, totalizer reset level and failure contact.
  task automatic t_pins();
    c = '0;
    c.efunc = fral_pkg::EF_ZERO;
    c.di_high = 1'b1;
    c.do1 = fral_pkg::DF_FAIL;
    zpulses = 0;
    wctrl();
    pin_to(1'b0);
    i_fral_pcs_model.set_level(1'b1);
    repeat (8) @(posedge clk);
    chk(zpulses, 32'd1);
    c.efunc = fral_pkg::EF_TOTAL;
    c.di_high = 1'b0;
    wctrl();
    pin_to(1'b0);
    chk(trst, 32'h1);
    pin_to(1'b1);
    chk(trst, 32'h0);
    diag <= 4'b0100;
    repeat (4) @(posedge clk);
    chk({c1, msg}, `FRAL_MSG_PARAM);
    diag <= 4'b0101;
    repeat (4) @(posedge clk);
    chk({c1, msg}, {1'b1, `FRAL_MSG_ROM});
    diag <= 4'b0000;
    $display("t_pins done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence; reset spans six cycles.
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_auto();
    t_ext();
    t_alarm();
    t_preset();
    t_pins();
    report_and_stop();
  end

  // The tests need well under this; a hang ends the run as a failure.
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule // fral_top_tb
